// ==== uart_line_partner.sv ====
// serial line partner: remote transmitter on the receive pin, observer of the transmit pin
`timescale 1ns/1ps
module uart_line_partner (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bench control
	input wire logic drive_i,
	input wire logic level_i,
	// line
	input wire logic tx_pin_i,
	output logic rx_pin_o,
	output logic tx_seen_o
);
	////////////////////////////////////////////////////////////////////////////////
	// released line floats to the pull-up, the idle mark level of a serial line
	assign rx_pin_o = drive_i ? level_i : 1'b1;

	// sampled like a real receiver would, one clock behind the pin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_seen_o <= 1'b0;
		end else begin
			tx_seen_o <= tx_pin_i;
		end
	end
endmodule

// ==== uart_tbi_pkg.sv ====
// constants shared by the time-out, baud divider and infrared line block
package uart_tbi_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// receive word path
	localparam int WORD_W = 8;
	localparam int FIFO_DEPTH = 8;

	////////////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_TIMEOUT = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_BAUD = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_LINE = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_IDLE = 8'h40;

	// reset values
	localparam logic [DATA_W-1:0] RST_TIMEOUT = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RST_BAUD = 32'h0F00_0000;
	localparam logic [DATA_W-1:0] RST_LINE = 32'h0000_0040;
	localparam logic [DATA_W-1:0] RST_IDLE = 32'h0000_0000;

	// writable bit masks, reserved bits read as zero
	localparam logic [DATA_W-1:0] MASK_TIMEOUT = 32'h0000_007F;
	localparam logic [DATA_W-1:0] MASK_BAUD = 32'h3F00_FFFF;
	localparam logic [DATA_W-1:0] MASK_LINE = 32'h0000_0066;
	localparam logic [DATA_W-1:0] MASK_IDLE = 32'h0000_0001;

	////////////////////////////////////////////////////////////////////////////////
	// field layout
	localparam int CMP_W = 7;
	localparam int BAUD_EN_BIT = 29;
	localparam int BAUD_BYP_BIT = 28;
	localparam int PRESC_LSB = 24;
	localparam int PRESC_W = 4;
	localparam int DIV_W = 16;
	localparam int LINE_RX_LINE_INVERT_BIT = 6;
	localparam int LINE_TX_LINE_INVERT_BIT = 5;
	localparam int LINE_LOOP_BIT = 2;
	localparam int LINE_DIR_BIT = 1;
	localparam int IDLE_EN_BIT = 0;
	localparam int IDLE_FLAG_BIT = 1;
	localparam int IDLE_CNT_LSB = 8;

	// first stage divide values, minus one
	localparam logic [PRESC_W-1:0] M_FIXED_M1 = 4'hF;
	localparam logic [PRESC_W-1:0] M_BYPASS_M1 = 4'h0;

	// line idle levels
	localparam logic TX_IDLE_LVL = 1'b0;
	localparam logic RX_IDLE_LVL = 1'b1;

	// width of a full baud period in clock cycles
	localparam int PERIOD_W = 22;

endpackage

// ==== uart_timeout_baud_infrared.sv ====
// receive time-out, two stage baud divider and infrared line control
`timescale 1ns/1ps

// Contract
// - a word written into the receive fifo clears and restarts the 7-bit time-out count
// - count equal to compare value sets the idle flag; interrupt needs its enable
// - idle flag clears on a new received word or on an empty fifo
// - time-out count advances once per baud period, not per clock
// - mode 0: baud equals clock over sixteen times divisor plus two
// - mode 1: clock over prescaler plus one times divisor plus two; prescaler at least 8
// - mode 2: clock over divisor plus two; software keeps divisor at least 3
// - bypass bit forces first stage to one and ignores the prescaler field
// - receive invert bit inverts the incoming line, clear passes it unchanged
// - transmit invert bit inverts the outgoing line, clear drives it unchanged
// - loopback bit routes own transmit output back into the receive input
// - direction bit clear enables receiver, set enables transmitter; one at a time unless loopback is set, which keeps the receiver on
module uart_timeout_baud_infrared (
	// clock, reset, enable
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic CE_I,
	// apb slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [uart_tbi_pkg::ADDR_W-1:0] PADDR_I,
	input wire logic [uart_tbi_pkg::DATA_W-1:0] PWDATA_I,
	output logic [uart_tbi_pkg::DATA_W-1:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// received words from the decoder
	input wire logic RX_WORD_VALID_I,
	input wire logic [uart_tbi_pkg::WORD_W-1:0] RX_WORD_I,
	output logic RX_WORD_READY_O,
	// received words to the reader
	output logic RX_READ_VALID_O,
	output logic [uart_tbi_pkg::WORD_W-1:0] RX_READ_DATA_O,
	input wire logic RX_READ_READY_I,
	// status
	output logic RX_FIFO_EMPTY_O,
	output logic RX_IDLE_INTERRUPT_O,
	// baud tick to transmitter and receiver
	output logic BAUD_TICK_O,
	// serial line
	input wire logic TX_BIT_I,
	output logic TX_PIN_O,
	input wire logic RX_PIN_I,
	output logic RX_BIT_O
);
	import uart_tbi_pkg::*;

	logic [DATA_W-1:0] timeout_r;
	logic [DATA_W-1:0] baud_r;
	logic [DATA_W-1:0] line_r;
	logic idle_en_r;
	logic pready_r;
	logic [DATA_W-1:0] prdata_r;
	logic [PRESC_W-1:0] pre_cnt_r;
	logic [DIV_W:0] div_cnt_r;
	logic [CMP_W-1:0] cnt_r;
	logic [CMP_W-1:0] cnt_nxt;
	logic idle_flag_r;
	logic idle_flag_nxt;
	logic tx_pin_r;
	logic rx_bit_r;
	logic fifo_empty;
	logic fifo_wr_ready;

	////////////////////////////////////////////////////////////////////////////////
	// apb decode; one wait state so read data come from a flop
	wire apb_access = PSEL_I & PENABLE_I;
	wire apb_done = apb_access & pready_r & CE_I;
	wire wr_en = apb_done & PWRITE_I;
	wire hit_timeout = PADDR_I == OFS_TIMEOUT;
	wire hit_baud = PADDR_I == OFS_BAUD;
	wire hit_line = PADDR_I == OFS_LINE;
	wire hit_idle = PADDR_I == OFS_IDLE;
	wire hit_any = hit_timeout | hit_baud | hit_line | hit_idle;
	wire wr_timeout = wr_en & hit_timeout;
	wire wr_baud = wr_en & hit_baud;
	wire wr_line = wr_en & hit_line;
	wire wr_idle = wr_en & hit_idle;

	wire [DATA_W-1:0] idle_view = DATA_W'({cnt_r, 6'h00, idle_flag_r, idle_en_r});
	wire [DATA_W-1:0] rd_mux = hit_timeout ? timeout_r :
		hit_baud ? baud_r :
		hit_line ? line_r :
		hit_idle ? idle_view : '0;

	assign PREADY_O = pready_r;
	assign PSLVERR_O = pready_r & ~hit_any;
	assign PRDATA_O = prdata_r;

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			pready_r <= 1'b0;
			prdata_r <= '0;
		end else if (CE_I) begin
			pready_r <= apb_access & ~pready_r;
			prdata_r <= (apb_access & ~pready_r) ? rd_mux : prdata_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			timeout_r <= RST_TIMEOUT;
			baud_r <= RST_BAUD;
			line_r <= RST_LINE;
			idle_en_r <= RST_IDLE[IDLE_EN_BIT];
		end else if (CE_I) begin
			timeout_r <= wr_timeout ? (PWDATA_I & MASK_TIMEOUT) : timeout_r;
			baud_r <= wr_baud ? (PWDATA_I & MASK_BAUD) : baud_r;
			line_r <= wr_line ? (PWDATA_I & MASK_LINE) : line_r;
			idle_en_r <= wr_idle ? (PWDATA_I[IDLE_EN_BIT] & MASK_IDLE[IDLE_EN_BIT]) : idle_en_r;
		end
	end

	wire [CMP_W-1:0] cmp_val = timeout_r[CMP_W-1:0];
	wire presc_en = baud_r[BAUD_EN_BIT];
	wire presc_byp = baud_r[BAUD_BYP_BIT];
	wire [PRESC_W-1:0] presc_val = baud_r[PRESC_LSB +: PRESC_W];
	wire [DIV_W-1:0] baud_div = baud_r[DIV_W-1:0];
	wire rx_inv = line_r[LINE_RX_LINE_INVERT_BIT];
	wire tx_inv = line_r[LINE_TX_LINE_INVERT_BIT];
	wire loop_en = line_r[LINE_LOOP_BIT];
	wire dir_tx = line_r[LINE_DIR_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// baud divider: first stage M, second stage divisor plus two
	// prescaler limits are the programmer's job; small values just run fast
	wire [PRESC_W-1:0] m_minus1 = presc_byp ? M_BYPASS_M1 :
		presc_en ? presc_val : M_FIXED_M1;
	wire pre_tick = pre_cnt_r == m_minus1;
	wire [DIV_W:0] div_last = {1'b0, baud_div} + 17'h0_0001;
	wire baud_tick = pre_tick & (div_cnt_r == div_last);

	assign BAUD_TICK_O = baud_tick & CE_I;

	// a write to the divisor restarts both stages so no half period escapes
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			pre_cnt_r <= '0;
			div_cnt_r <= '0;
		end else if (CE_I) begin
			pre_cnt_r <= (wr_baud | pre_tick) ? '0 : PRESC_W'(pre_cnt_r + 1'b1);
			div_cnt_r <= (wr_baud | baud_tick) ? '0 :
				pre_tick ? (DIV_W+1)'(div_cnt_r + 1'b1) : div_cnt_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// receive time-out
	wire rx_push = RX_WORD_VALID_I & fifo_wr_ready;
	wire match = cnt_r == cmp_val;

	always_comb begin
		cnt_nxt = cnt_r;
		if (rx_push) begin
			cnt_nxt = '0;
		end else if (baud_tick && !fifo_empty && !match) begin
			cnt_nxt = CMP_W'(cnt_r + 1'b1);
		end
	end

	// a push restarts the count, so it outranks a match seen in that cycle
	always_comb begin
		idle_flag_nxt = idle_flag_r;
		if (rx_push || fifo_empty) begin
			idle_flag_nxt = 1'b0;
		end else if (match) begin
			idle_flag_nxt = 1'b1;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			cnt_r <= '0;
			idle_flag_r <= 1'b0;
		end else if (CE_I) begin
			cnt_r <= cnt_nxt;
			idle_flag_r <= idle_flag_nxt;
		end
	end

	assign RX_IDLE_INTERRUPT_O = idle_flag_r & idle_en_r;

	////////////////////////////////////////////////////////////////////////////////
	// infrared line control
	wire tx_line = TX_BIT_I ^ tx_inv;
	wire rx_pin_inv = RX_PIN_I ^ rx_inv;
	wire rx_enable = ~dir_tx | loop_en;
	wire rx_src = loop_en ? (tx_line ^ rx_inv) : rx_pin_inv;
	wire rx_bit_nxt = rx_enable ? rx_src : RX_IDLE_LVL;
	wire tx_pin_nxt = dir_tx ? tx_line : TX_IDLE_LVL;

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			tx_pin_r <= TX_IDLE_LVL;
			rx_bit_r <= RX_IDLE_LVL;
		end else if (CE_I) begin
			tx_pin_r <= tx_pin_nxt;
			rx_bit_r <= rx_bit_nxt;
		end
	end

	assign TX_PIN_O = tx_pin_r;
	assign RX_BIT_O = rx_bit_r;

	////////////////////////////////////////////////////////////////////////////////
	// receive fifo
	uart_word_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.clk_i(CLK_I),
		.rst_i(RST_I),
		.ce_i(CE_I),
		.wr_valid_i(RX_WORD_VALID_I),
		.wr_data_i(RX_WORD_I),
		.wr_ready_o(fifo_wr_ready),
		.rd_valid_o(RX_READ_VALID_O),
		.rd_data_o(RX_READ_DATA_O),
		.rd_ready_i(RX_READ_READY_I),
		.empty_o(fifo_empty),
		.full_o()
	);

	assign RX_WORD_READY_O = fifo_wr_ready;
	assign RX_FIFO_EMPTY_O = fifo_empty;

	////////////////////////////////////////////////////////////////////////////////
	// checks; baud gap counted in enabled cycles
	logic [PERIOD_W-1:0] gap_r;
	wire [DIV_W:0] div_plus2 = {1'b0, baud_div} + 17'h0_0002;
	// expected periods built from the fields, not from the divider's own mux
	wire [PERIOD_W-1:0] period_m0 = PERIOD_W'({div_plus2, 4'h0});
	wire [PERIOD_W-1:0] period_m1 = PERIOD_W'({1'b0, presc_val} + 5'h01) *
		PERIOD_W'(div_plus2);
	wire [PERIOD_W-1:0] period_m2 = PERIOD_W'(div_plus2);
	wire mode0 = ~presc_en & ~presc_byp;
	wire mode1 = presc_en & ~presc_byp;
	wire mode2 = presc_en & presc_byp;

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			gap_r <= '0;
		end else if (CE_I) begin
			gap_r <= (wr_baud | baud_tick) ? '0 : PERIOD_W'(gap_r + 1'b1);
		end
	end

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	a_push_restart: assert property (CE_I && rx_push |=> cnt_r == '0)
		else $error("time-out count not restarted by a new word");
	a_flag_on_match: assert property (CE_I && match && !rx_push && !fifo_empty
		|=> idle_flag_r)
		else $error("idle flag not set at compare match");
	a_irq_gated: assert property (RX_IDLE_INTERRUPT_O |-> idle_en_r && idle_flag_r)
		else $error("idle interrupt raised without enable and flag");
	a_flag_clear: assert property (CE_I && (rx_push || fifo_empty) |=> !idle_flag_r)
		else $error("idle flag survived a new word or empty fifo");
	a_count_per_baud: assert property (CE_I && !baud_tick && !rx_push |=> $stable(cnt_r))
		else $error("time-out count moved without a baud tick");
	a_mode0_period: assert property (CE_I && baud_tick && mode0 && !wr_baud
		|-> gap_r == PERIOD_W'(period_m0 - 1'b1))
		else $error("mode 0 baud period wrong");
	a_mode1_period: assert property (CE_I && baud_tick && mode1 && !wr_baud
		|-> gap_r == PERIOD_W'(period_m1 - 1'b1))
		else $error("mode 1 baud period wrong");
	a_mode2_period: assert property (CE_I && baud_tick && mode2 && !wr_baud
		|-> gap_r == PERIOD_W'(period_m2 - 1'b1))
		else $error("mode 2 baud period wrong");
	a_rx_invert: assert property (CE_I && rx_enable && !loop_en
		|=> RX_BIT_O == $past(rx_pin_inv))
		else $error("receive line polarity wrong");
	a_tx_invert: assert property (CE_I && dir_tx |=> TX_PIN_O == $past(tx_line))
		else $error("transmit line polarity wrong");
	a_loopback_path: assert property (CE_I && loop_en
		|=> RX_BIT_O == ($past(tx_line) ^ $past(rx_inv)))
		else $error("loopback does not feed transmit into receive");
	a_direction_sel: assert property (CE_I && !dir_tx ##1 CE_I && !dir_tx
		|-> TX_PIN_O == TX_IDLE_LVL)
		else $error("transmitter active while receiver selected");
	a_count_hold: assert property (CE_I && (match || fifo_empty) && !rx_push
		|=> $stable(cnt_r))
		else $error("time-out count ran past match or on empty fifo");

	// bus answer timing, one wait state and a single ready cycle; baud tick one cycle wide
	a_apb_wait_state: assert property (CE_I && PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
		else $error("access phase not answered after one wait state");
	a_ready_single: assert property (CE_I && PREADY_O |=> !PREADY_O)
		else $error("ready stood longer than one cycle");
	a_tick_single: assert property (BAUD_TICK_O |=> !BAUD_TICK_O)
		else $error("baud tick lasted more than one cycle");

	c_idle_flag: cover property (CE_I && match && !fifo_empty ##1 idle_flag_r);
	c_mode1_tick: cover property (BAUD_TICK_O && mode1);
	c_mode2_tick: cover property (BAUD_TICK_O && mode2);
	c_loopback: cover property (loop_en && dir_tx && CE_I);
endmodule

// ==== uart_timeout_baud_infrared_bench.sv ====
// self-checking bench for the time-out, baud divider and infrared line block
`timescale 1ns/1ps
module uart_timeout_baud_infrared_bench;
	import uart_tbi_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = 8'h00;
	logic [DATA_W-1:0] pwdata = 32'h0000_0000;
	logic wvalid = 1'b0;
	logic [WORD_W-1:0] wword = 8'h00;
	logic rready = 1'b0;
	logic tx_bit = 1'b0;
	logic drive = 1'b0;
	logic level = 1'b1;
	logic [DATA_W-1:0] prdata, rd;
	logic pready, pslverr, err, wready, rvalid, fempty, idle_irq, tick, tx_pin, rx_bit, rx_pin;
	logic tx_seen;
	logic [WORD_W-1:0] rword;
	int mismatches = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [ADDR_W-1:0] ofs [4] = '{OFS_TIMEOUT, OFS_BAUD, OFS_LINE, OFS_IDLE};
	logic [DATA_W-1:0] rstv [4] = '{RST_TIMEOUT, RST_BAUD, RST_LINE, RST_IDLE};
	logic [DATA_W-1:0] msk [4] = '{MASK_TIMEOUT, MASK_BAUD, MASK_LINE, MASK_IDLE};
	logic [DATA_W-1:0] bcfg [5] = '{32'h0000_0000, 32'h2800_0001, 32'h2F00_0002, 32'h3000_0003,
		32'h1000_0004};
	int bper [5] = '{16 * (0 + 2), (8 + 1) * (1 + 2), (15 + 1) * (2 + 2), 3 + 2, 1 * (4 + 2)};
	logic [7:0] lv [8] = '{8'h00, 8'h02, 8'h20, 8'h22, 8'h40, 8'h42, 8'h04, 8'h66};

	initial forever #2 clk = ~clk;

	uart_timeout_baud_infrared u_dut (.CLK_I(clk), .RST_I(rst), .CE_I(ce), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .RX_WORD_VALID_I(wvalid),
		.RX_WORD_I(wword), .RX_WORD_READY_O(wready), .RX_READ_VALID_O(rvalid),
		.RX_READ_DATA_O(rword), .RX_READ_READY_I(rready), .RX_FIFO_EMPTY_O(fempty),
		.RX_IDLE_INTERRUPT_O(idle_irq), .BAUD_TICK_O(tick), .TX_BIT_I(tx_bit),
		.TX_PIN_O(tx_pin), .RX_PIN_I(rx_pin), .RX_BIT_O(rx_bit));

	uart_line_partner u_line (.clk_i(clk), .rst_i(rst), .drive_i(drive), .level_i(level),
		.tx_pin_i(tx_pin), .rx_pin_o(rx_pin), .tx_seen_o(tx_seen));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// apb, push and pop each enter one edge late so no signal is assigned twice in a time step
	// no local limit on a wait in apb, push and pop; only the hang guard ends one
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		do begin @(posedge clk); end while (pready !== 1'b1);
		{rd, err} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
	endtask

	task automatic push(input logic [WORD_W-1:0] w);
		@(posedge clk);
		{wvalid, wword} <= {1'b1, w};
		do begin @(posedge clk); end while (wready !== 1'b1);
		wvalid <= 1'b0;
	endtask

	task automatic pop(input logic [WORD_W-1:0] exp);
		@(posedge clk);
		rready <= 1'b1;
		do begin @(posedge clk); end while (rvalid !== 1'b1);
		check("read word", rword, exp);
		rready <= 1'b0;
	endtask

	task automatic period(output int p);
		int n;
		n = 0;
		do begin @(posedge clk); n++; end while (tick !== 1'b1 && n < 200);
		p = 0;
		do begin @(posedge clk); p++; end while (tick !== 1'b1 && p < 200);
	endtask

	function automatic logic [1:0] line_exp(input logic [7:0] v, input logic tb, input logic rp);
		logic s;
		s = v[LINE_LOOP_BIT] ? tb ^ v[LINE_TX_LINE_INVERT_BIT] : rp;
		return {v[LINE_DIR_BIT] ? tb ^ v[LINE_TX_LINE_INVERT_BIT] : TX_IDLE_LVL,
			(!v[LINE_DIR_BIT] || v[LINE_LOOP_BIT]) ? s ^ v[LINE_RX_LINE_INVERT_BIT] : RX_IDLE_LVL};
	endfunction

	// hang guard, far above the thousand or so cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int p;
		int n;
		logic [1:0] e;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, ofs[i], 32'h0000_0000);
			check("reset value", rd, rstv[i]);
			apb(1'b1, ofs[i], 32'hFFFF_FFFF);
			apb(1'b0, ofs[i], 32'h0000_0000);
			check("written value", rd, msk[i]);
			check("slave error", err, 1'b0);
		end
		apb(1'b1, 8'h30, 32'hFFFF_FFFF);
		apb(1'b0, 8'h30, 32'h0000_0000);
		check("unmapped data", rd, 32'h0000_0000);
		check("unmapped error", err, 1'b1);
		$display("test registers done");

		for (int i = 0; i < 5; i++) begin
			apb(1'b1, OFS_BAUD, bcfg[i]);
			period(p);
			period(p);
			check("baud period", p, bper[i]);
		end
		$display("test baud done");

		apb(1'b1, OFS_BAUD, 32'h0000_0000);
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, OFS_LINE, {24'h00_0000, lv[i]});
			for (int b = 0; b < 4; b++) begin
				{tx_bit, drive, level} <= {b[1], 1'b1, b[0]};
				repeat (4) @(posedge clk);
				e = line_exp(lv[i], b[1], b[0]);
				check("tx pin", tx_seen, e[1]);
				check("rx bit", rx_bit, e[0]);
			end
		end
		$display("test line done");

		apb(1'b1, OFS_BAUD, 32'h3000_0003);
		apb(1'b1, OFS_TIMEOUT, 32'h0000_0003);
		apb(1'b1, OFS_IDLE, 32'h0000_0001);
		push(8'h5A);
		n = 0;
		do begin @(posedge clk); n++; end while (idle_irq !== 1'b1 && n < 100);
		check("idle delay", n >= 12 && n <= 18, 1'b1);
		repeat (30) @(posedge clk);
		apb(1'b0, OFS_IDLE, 32'h0000_0000);
		check("held count", rd[14:8], 7'h03);
		check("idle flag", rd[IDLE_FLAG_BIT], 1'b1);
		apb(1'b1, OFS_IDLE, 32'h0000_0000);
		@(posedge clk);
		check("masked interrupt", idle_irq, 1'b0);
		push(8'hA5);
		apb(1'b0, OFS_IDLE, 32'h0000_0000);
		check("flag after word", rd[IDLE_FLAG_BIT], 1'b0);
		check("restarted count", rd[14:8] <= 7'h01, 1'b1);
		// flag must be set again so that the empty clear below means something
		repeat (30) @(posedge clk);
		apb(1'b0, OFS_IDLE, 32'h0000_0000);
		check("flag rearmed", rd[IDLE_FLAG_BIT], 1'b1);
		pop(8'h5A);
		pop(8'hA5);
		repeat (40) @(posedge clk);
		apb(1'b0, OFS_IDLE, 32'h0000_0000);
		check("flag when empty", rd[IDLE_FLAG_BIT], 1'b0);
		$display("test timeout done");

		// reader stalled so the buffer must refuse the ninth word
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			push(8'hC0 + 8'(i));
		end
		@(posedge clk);
		{wvalid, wword} <= {1'b1, 8'hEE};
		repeat (3) @(posedge clk);
		wvalid <= 1'b0;
		check("full refuses", wready, 1'b0);
		check("not empty", fempty, 1'b0);
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			pop(8'hC0 + 8'(i));
		end
		repeat (3) @(posedge clk);
		check("drained empty", fempty, 1'b1);
		check("drained valid", rvalid, 1'b0);
		$display("test fifo done");

		// enable low: an offered word must not be taken
		{ce, wvalid, wword} <= {1'b0, 1'b1, 8'h3C};
		repeat (4) @(posedge clk);
		wvalid <= 1'b0;
		@(posedge clk);
		ce <= 1'b1;
		repeat (2) @(posedge clk);
		check("frozen push", fempty, 1'b1);
		$display("test enable done");
		give_verdict();
	end
endmodule

// ==== uart_word_fifo.sv ====
// receive word fifo with registered read data
`timescale 1ns/1ps
module uart_word_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// fill side
	input wire logic wr_valid_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	output logic wr_ready_o,
	// drain side
	output logic rd_valid_o,
	output logic [WIDTH-1:0] rd_data_o,
	input wire logic rd_ready_i,
	// level
	output logic empty_o,
	output logic full_o
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wptr_r;
	logic [PTR_W-1:0] rptr_r;
	logic [CNT_W-1:0] total_r;
	logic out_valid_r;
	logic [WIDTH-1:0] out_data_r;

	////////////////////////////////////////////////////////////////////////////////
	// the output register counts as one of the DEPTH slots
	wire push = wr_valid_i & ~full_o;
	wire pop = out_valid_r & rd_ready_i;
	wire [CNT_W-1:0] mem_cnt = total_r - CNT_W'(out_valid_r);
	wire load = (~out_valid_r | pop) & (mem_cnt != '0);
	wire [CNT_W-1:0] total_nxt = total_r + CNT_W'(push) - CNT_W'(pop);

	assign full_o = total_r == CNT_FULL;
	assign empty_o = total_r == '0;
	assign wr_ready_o = ~full_o;
	assign rd_valid_o = out_valid_r;
	assign rd_data_o = out_data_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wptr_r <= '0;
			rptr_r <= '0;
			total_r <= '0;
			out_valid_r <= 1'b0;
			out_data_r <= '0;
		end else if (ce_i) begin
			wptr_r <= push ? PTR_W'(wptr_r + 1'b1) : wptr_r;
			rptr_r <= load ? PTR_W'(rptr_r + 1'b1) : rptr_r;
			total_r <= total_nxt;
			out_valid_r <= load | (out_valid_r & ~pop);
			out_data_r <= load ? mem[rptr_r] : out_data_r;
		end
	end

	// storage has no reset, only written on accepted words
	always_ff @(posedge clk_i) begin
		if (ce_i && push) begin
			mem[wptr_r] <= wr_data_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	a_fifo_no_overrun: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && full_o && !rd_ready_i) |=> full_o && (total_r == CNT_FULL))
		else $error("fifo level moved while full and stalled");
	a_fifo_empty_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		empty_o |-> !rd_valid_o)
		else $error("fifo shows data while empty");
	c_fifo_fills: cover property (@(posedge clk_i) disable iff (rst_i) full_o);
endmodule
